//--- include/rst_guard_pkg.sv
// Purpose: constants of the reset-source and timeout guard block
// Assumes: 100 MHz reference clock, 8-bit register port
// Notes: cause flags and selects share bit positions but differ on read and write
package rst_guard_pkg;
	localparam logic [7:0] ADDR_CAUSE = 8'hEF;
	localparam logic [7:0] ADDR_GUARD = 8'hFF;
	localparam logic [7:0] CODE_RESTART = 8'hA5;
	localparam logic [7:0] CODE_DIS_FIRST = 8'hDE;
	localparam logic [7:0] CODE_DIS_SECOND = 8'hAD;
	localparam logic [7:0] CODE_LOCK = 8'hFF;
	localparam int BIT_DEBUG = 7;
	localparam int BIT_CONV = 6;
	localparam int BIT_COMP = 5;
	localparam int BIT_SOFT = 4;
	localparam int BIT_GUARD = 3;
	localparam int BIT_CLK = 2;
	localparam int BIT_POR = 1;
	localparam int BIT_PIN = 0;
	localparam int BIT_INTERVAL_WR = 7;
	localparam int BIT_GUARD_ACTIVE = 4;
	localparam logic [2:0] INTERVAL_RST = 3'h7;
	localparam logic [2:0] DIS_WINDOW = 3'h4;
	localparam int GUARD_W = 21;
	localparam int HOLD_W = 24;
	localparam int CLK_PERIOD_NS = 10;
	localparam int CLOCK_LOSS_TIMEOUT_US = 100;
	localparam int SUPPLY_TIMEOUT_MS = 100;
	localparam int POR_HOLD_DEFAULT = SUPPLY_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam logic [HOLD_W-1:0] RELEASE_CYCLES = 24'h00000C;
	localparam logic [7:0] RDATA_RST = 8'h00;
	typedef enum logic [2:0] {
		CAUSE_POR,
		CAUSE_PIN,
		CAUSE_CLK,
		CAUSE_COMP,
		CAUSE_CONV,
		CAUSE_GUARD,
		CAUSE_SOFT
	} cause_t;
endpackage : rst_guard_pkg

//--- core/watchdog_and_reset_sources.sv
// Purpose: reset sequencer, reset-cause register and timeout guard
// Assumes: all inputs synchronous to i_ref_clk; clock-loss one-shot is analog
// Notes: comparator and clock-loss resets reach o_sys_rst_n without a clock edge
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_reset_sources
	import rst_guard_pkg::*;
#(
	parameter int unsigned POR_HOLD_CYCLES = POR_HOLD_DEFAULT
)
(
	input wire logic i_ref_clk,
	input wire logic i_arst_n,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	input wire logic i_supply_ok,
	input wire logic i_pin_rst_n,
	input wire logic i_clock_loss_enable,
	input wire logic i_clock_lost,
	input wire logic i_comp_lt,
	input wire logic i_convert_start_input_n,
	input wire logic i_debug_port_reset,
	output logic o_sys_rst_n,
	output logic o_rst_pin_o,
	output logic o_rst_pin_oe
);

	logic in_reset_q;
	cause_t cause_q;
	logic [HOLD_W-1:0] hold_q;
	logic [6:0] flag_q;
	logic conv_sel_q;
	logic comp_sel_q;
	logic guard_en_q;
	logic lock_q;
	logic [2:0] interval_q;
	logic [GUARD_W-1:0] count_q;
	logic [2:0] arm_q;
	logic [7:0] rdata_q;

	logic wr_cause;
	logic wr_guard;
	logic src_supply;
	logic src_pin;
	logic src_clk;
	logic src_comp;
	logic src_conv;
	logic src_guard;
	logic src_soft;
	logic src_power_on_flag;
	logic pin_drive;
	logic any_src;
	logic level_hold;
	logic exit_now;
	cause_t entry_cause;
	logic [GUARD_W-1:0] last_tick;

	// timeout is 4^(3+n) = 2^(6+2n); n = 7 gives 2^20, still inside 21 bits
	function automatic logic [GUARD_W-1:0] guard_last(input logic [2:0] iv);
		logic [4:0] sh;
		sh = 5'h6 + {1'b0, iv, 1'b0};
		guard_last = (GUARD_W'(1) << sh) - GUARD_W'(1);
	endfunction : guard_last

	function automatic logic [HOLD_W-1:0] hold_for(input cause_t c);
		hold_for = (c == CAUSE_POR) ? HOLD_W'(POR_HOLD_CYCLES) : RELEASE_CYCLES;
	endfunction : hold_for

	// firmware is halted in reset, so writes landing then are dropped
	assign wr_cause = i_wr && (i_addr == ADDR_CAUSE) && !in_reset_q;
	assign wr_guard = i_wr && (i_addr == ADDR_GUARD) && !in_reset_q;
	assign last_tick = guard_last(interval_q);

	assign src_supply = !i_supply_ok;
	// the pin reads back our own low drive; that must not count as an external reset
	assign pin_drive = in_reset_q && (cause_q == CAUSE_POR);
	assign src_pin = !i_pin_rst_n && !pin_drive;
	assign src_clk = i_clock_loss_enable && i_clock_lost;
	assign src_comp = comp_sel_q && i_comp_lt;
	assign src_conv = conv_sel_q && !i_convert_start_input_n;
	assign src_guard = guard_en_q && (count_q == last_tick);
	assign src_soft = wr_cause && i_wdata[BIT_SOFT];
	assign src_power_on_flag = wr_cause && i_wdata[BIT_POR];
	assign any_src = src_supply || src_pin || src_clk || src_comp || src_conv
		|| src_guard || src_soft || src_power_on_flag;

	always_comb
	begin
		if (src_supply || src_power_on_flag)
			entry_cause = CAUSE_POR;
		else if (src_pin)
			entry_cause = CAUSE_PIN;
		else if (src_clk)
			entry_cause = CAUSE_CLK;
		else if (src_comp)
			entry_cause = CAUSE_COMP;
		else if (src_conv)
			entry_cause = CAUSE_CONV;
		else if (src_guard)
			entry_cause = CAUSE_GUARD;
		else
			entry_cause = CAUSE_SOFT;
	end

	// level sources keep the device in reset for as long as they stay asserted
	assign level_hold = src_pin || src_clk
		|| ((cause_q == CAUSE_COMP) && i_comp_lt)
		|| ((cause_q == CAUSE_CONV) && !i_convert_start_input_n);
	assign exit_now = in_reset_q && !src_supply && !level_hold && (hold_q == '0);

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			in_reset_q <= 1'b1;
			cause_q <= CAUSE_POR;
			hold_q <= HOLD_W'(POR_HOLD_CYCLES);
		end
		else if (!in_reset_q)
		begin
			if (any_src)
			begin
				in_reset_q <= 1'b1;
				cause_q <= entry_cause;
				hold_q <= hold_for(entry_cause);
			end
		end
		else if (src_supply)
		begin
			cause_q <= CAUSE_POR;
			hold_q <= HOLD_W'(POR_HOLD_CYCLES);
		end
		else if (level_hold)
			hold_q <= hold_for(cause_q);
		else if (hold_q != '0)
			hold_q <= hold_q - HOLD_W'(1);
		else
			in_reset_q <= 1'b0;
	end

	// one flag per cause, written as the device leaves reset
	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			flag_q <= '0;
		else if (exit_now)
		begin
			flag_q <= '0;
			flag_q[BIT_POR] <= (cause_q == CAUSE_POR);
			flag_q[BIT_PIN] <= (cause_q == CAUSE_PIN);
			flag_q[BIT_CLK] <= (cause_q == CAUSE_CLK);
			flag_q[BIT_COMP] <= (cause_q == CAUSE_COMP);
			flag_q[BIT_CONV] <= (cause_q == CAUSE_CONV);
			flag_q[BIT_GUARD] <= (cause_q == CAUSE_GUARD);
			flag_q[BIT_SOFT] <= (cause_q == CAUSE_SOFT);
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			conv_sel_q <= 1'b0;
			comp_sel_q <= 1'b0;
		end
		else if (in_reset_q || any_src)
		begin
			conv_sel_q <= 1'b0;
			comp_sel_q <= 1'b0;
		end
		else if (wr_cause)
		begin
			conv_sel_q <= i_wdata[BIT_CONV];
			comp_sel_q <= i_wdata[BIT_COMP];
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
		begin
			guard_en_q <= 1'b1;
			lock_q <= 1'b0;
			interval_q <= INTERVAL_RST;
			count_q <= '0;
			arm_q <= '0;
		end
		else if (in_reset_q)
		begin
			guard_en_q <= 1'b1;
			lock_q <= 1'b0;
			interval_q <= INTERVAL_RST;
			count_q <= '0;
			arm_q <= '0;
		end
		else
		begin
			if (guard_en_q)
				count_q <= count_q + GUARD_W'(1);
			if (arm_q != '0)
				arm_q <= arm_q - 3'h1;
			if (wr_guard)
			begin
				if (!i_wdata[BIT_INTERVAL_WR])
					interval_q <= i_wdata[2:0];
				unique case (i_wdata)
					CODE_RESTART:
					begin
						guard_en_q <= 1'b1;
						count_q <= '0;
					end
					CODE_DIS_FIRST:
						arm_q <= DIS_WINDOW;
					CODE_DIS_SECOND:
					begin
						// lockout wins; an unarmed second code is ignored
						if (arm_q != '0 && !lock_q)
							guard_en_q <= 1'b0;
						arm_q <= '0;
					end
					CODE_LOCK:
						lock_q <= 1'b1;
					default:
						arm_q <= '0;
				endcase
			end
		end
	end

	always_ff @(posedge i_ref_clk or negedge i_arst_n)
	begin
		if (!i_arst_n)
			rdata_q <= RDATA_RST;
		else if (i_rd && i_addr == ADDR_CAUSE)
			rdata_q <= {i_debug_port_reset, flag_q};
		else if (i_rd && i_addr == ADDR_GUARD)
		begin
			rdata_q <= RDATA_RST;
			rdata_q[BIT_GUARD_ACTIVE] <= guard_en_q;
			rdata_q[2:0] <= interval_q;
		end
		else
			rdata_q <= RDATA_RST;
	end

	assign o_rdata = rdata_q;
	// comparator and clock-loss paths bypass the flops so they act with no clock
	assign o_sys_rst_n = !(in_reset_q || src_comp || src_clk);
	assign o_rst_pin_o = 1'b0;
	assign o_rst_pin_oe = pin_drive;

	a_restart_clears: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		wr_guard && i_wdata == CODE_RESTART && !any_src |=> guard_en_q && count_q == '0)
		else $error("restart code did not enable and clear the guard");

	a_disable_pair: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		wr_guard && i_wdata == CODE_DIS_FIRST && !lock_q && !any_src
		##1 wr_guard && i_wdata == CODE_DIS_SECOND && !any_src |=> !guard_en_q)
		else $error("disable pair inside window did not stop the guard");

	a_disable_late: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		guard_en_q && arm_q == 3'h0 && wr_guard && i_wdata == CODE_DIS_SECOND |=> guard_en_q)
		else $error("unarmed second disable code stopped the guard");

	a_lock_holds: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		lock_q && guard_en_q && !in_reset_q |=> guard_en_q || in_reset_q)
		else $error("guard was disabled after lockout");

	a_overflow_resets: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		!in_reset_q && guard_en_q && count_q == last_tick |=> in_reset_q)
		else $error("guard overflow did not enter reset");

	a_exit_guard_state: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		$fell(in_reset_q) |-> guard_en_q && interval_q == INTERVAL_RST && count_q == '0)
		else $error("guard not running with longest interval after reset");

	a_pin_untouched: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		in_reset_q && cause_q != CAUSE_POR |-> !o_rst_pin_oe)
		else $error("reset pin driven by an internal reset source");

	a_comp_reset_out: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		comp_sel_q && i_comp_lt |-> !o_sys_rst_n ##1 in_reset_q && cause_q == CAUSE_COMP
		|| cause_q == CAUSE_POR || cause_q == CAUSE_PIN || cause_q == CAUSE_CLK)
		else $error("comparator low did not reset the device");

	a_clock_flag: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		$fell(in_reset_q) |-> flag_q[BIT_CLK] == ($past(cause_q) == CAUSE_CLK))
		else $error("clock-loss flag does not match last reset cause");

	a_interval_write: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		wr_guard && !i_wdata[BIT_INTERVAL_WR] |=> interval_q == $past(i_wdata[2:0]))
		else $error("interval field not taken from write");

	a_interval_read: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
		i_rd && i_addr == ADDR_GUARD |=> o_rdata[2:0] == $past(interval_q))
		else $error("guard control read lost the interval");

endmodule : watchdog_and_reset_sources
`default_nettype wire

//--- verif/reset_pin_model.sv
// Purpose: far side of the open-drain reset pin: pull-up wire and an external reset button
// Assumes: the device only ever pulls the pin low, never drives it high
// Notes: the pull-up takes the wire high whenever nobody pulls it low
`timescale 1ns/1ps
`default_nettype none
module reset_pin_model
(
	input wire logic i_pin_o,
	input wire logic i_pin_oe,
	input wire logic i_press,
	output logic o_pin_level
);
	// the device's own drive loops back to its pin input, as on the board
	assign o_pin_level = !((i_pin_oe && !i_pin_o) || i_press);
endmodule : reset_pin_model
`default_nettype wire

//--- verif/watchdog_and_reset_sources_test.sv
// Purpose: register-level test of the reset sources and the timeout guard
// Assumes: power-on hold shortened to 20 cycles
// Notes: firmware keeps the comparator and the convert input quiet until their select is written
`timescale 1ns/1ps
`default_nettype none
module watchdog_and_reset_sources_test
	import rst_guard_pkg::*;
;
	logic i_ref_clk, i_arst_n, i_wr, i_rd, i_supply_ok, i_press, i_clock_loss_enable;
	logic i_clock_lost, i_comp_lt, i_convert_start_input_n, pin_level;
	logic [7:0] i_addr, i_wdata, o_rdata;
	logic o_sys_rst_n, o_rst_pin_o, o_rst_pin_oe;
	int mismatches, num_checks, n, k;
	logic [7:0] sel_tab [7] = '{8'h10, 8'h20, 8'h40, 8'h00, 8'h00, 8'h02, 8'h00};
	logic [7:0] cause_tab [7] = '{8'h10, 8'h20, 8'h40, 8'h04, 8'h01, 8'h02, 8'h02};

	watchdog_and_reset_sources #(.POR_HOLD_CYCLES(20)) watchdog_and_reset_sources_inst (
		.i_ref_clk(i_ref_clk), .i_arst_n(i_arst_n), .i_addr(i_addr), .i_wdata(i_wdata),
		.i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_supply_ok(i_supply_ok),
		.i_pin_rst_n(pin_level), .i_clock_loss_enable(i_clock_loss_enable),
		.i_clock_lost(i_clock_lost), .i_comp_lt(i_comp_lt),
		.i_convert_start_input_n(i_convert_start_input_n), .i_debug_port_reset(1'b0),
		.o_sys_rst_n(o_sys_rst_n), .o_rst_pin_o(o_rst_pin_o), .o_rst_pin_oe(o_rst_pin_oe));
	reset_pin_model reset_pin_model_inst (.i_pin_o(o_rst_pin_o), .i_pin_oe(o_rst_pin_oe),
		.i_press(i_press), .o_pin_level(pin_level));

	initial
	begin
		i_ref_clk = 1'b0;
		forever #5 i_ref_clk = ~i_ref_clk;
	end

	task automatic print_verdict();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : print_verdict

	task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask : chk

	task automatic wait_rst(input logic lvl);
		for (int i = 0; i < 300; i++)
		begin
			@(posedge i_ref_clk);
			#1;
			if (o_sys_rst_n === lvl)
				return;
		end
		mismatches++;
		print_verdict();
	endtask : wait_rst

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr

	// two writes on consecutive edges, strobe held high between them
	task automatic wr_pair(input logic [7:0] a, input logic [7:0] d1, input logic [7:0] d2);
		@(posedge i_ref_clk);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d1;
		@(posedge i_ref_clk);
		i_wdata <= d2;
		@(posedge i_ref_clk);
		i_wr <= 1'b0;
	endtask : wr_pair

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge i_ref_clk);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_ref_clk);
		i_rd <= 1'b0;
		#1;
		chk(o_rdata, exp);
	endtask : rd

	// kind: 0 soft, 1 comparator, 2 convert, 3 clock loss, 4 pin, 5 power-on write, 6 supply
	task automatic src(input int kind, input logic [7:0] sel, input logic [7:0] expc);
		if (sel != 8'h00)
			wr(ADDR_CAUSE, sel);
		@(posedge i_ref_clk);
		i_comp_lt <= (kind == 1);
		i_convert_start_input_n <= (kind != 2);
		i_clock_lost <= (kind == 3);
		i_press <= (kind == 4);
		i_supply_ok <= (kind != 6);
		if (kind == 1)
		begin
			#1;
			chk({7'h0, o_sys_rst_n}, 8'h00);
		end
		wait_rst(1'b0);
		chk({7'h0, o_rst_pin_oe}, {7'h0, kind >= 5});
		chk({7'h0, o_rst_pin_o}, 8'h00);
		repeat (4) @(posedge i_ref_clk);
		i_comp_lt <= 1'b0;
		i_convert_start_input_n <= 1'b1;
		i_clock_lost <= 1'b0;
		i_press <= 1'b0;
		i_supply_ok <= 1'b1;
		wait_rst(1'b1);
		rd(ADDR_CAUSE, expc);
		rd(ADDR_GUARD, 8'h17);
	endtask : src

	initial
	begin
		{i_wr, i_rd, i_press, i_clock_loss_enable, i_clock_lost, i_comp_lt} = '0;
		{i_addr, i_wdata} = '0;
		i_supply_ok = 1'b1;
		i_convert_start_input_n = 1'b1;
		i_arst_n = 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (16) @(posedge i_ref_clk);
		i_arst_n <= 1'b1;
		wait_rst(1'b1);
		chk({7'h0, o_rst_pin_oe}, 8'h00);
		rd(ADDR_CAUSE, 8'h02);
		rd(ADDR_GUARD, 8'h17);
		wr(ADDR_GUARD, 8'h00);
		rd(ADDR_GUARD, 8'h10);
		wr(ADDR_GUARD, 8'h83);
		rd(ADDR_GUARD, 8'h10);
		wr_pair(ADDR_GUARD, CODE_DIS_FIRST, CODE_DIS_SECOND);
		rd(ADDR_GUARD, 8'h00);
		wr(ADDR_GUARD, CODE_RESTART);
		rd(ADDR_GUARD, 8'h10);
		wr(ADDR_GUARD, CODE_DIS_FIRST);
		repeat (6) @(posedge i_ref_clk);
		wr(ADDR_GUARD, CODE_DIS_SECOND);
		rd(ADDR_GUARD, 8'h10);
		// interval 0 gives 4^3 = 64 cycles from the restart edge to the guard reset
		wr(ADDR_GUARD, CODE_RESTART);
		for (n = 0; n < 200; n++)
		begin
			@(posedge i_ref_clk);
			#1;
			if (o_sys_rst_n === 1'b0)
				break;
		end
		chk({7'h0, n >= 62 && n <= 65}, 8'h01);
		chk({7'h0, o_rst_pin_oe}, 8'h00);
		wait_rst(1'b1);
		rd(ADDR_CAUSE, 8'h08);
		rd(ADDR_GUARD, 8'h17);
		wr(ADDR_GUARD, CODE_LOCK);
		wr_pair(ADDR_GUARD, CODE_DIS_FIRST, CODE_DIS_SECOND);
		rd(ADDR_GUARD, 8'h17);
		@(posedge i_ref_clk);
		i_clock_lost <= 1'b1;
		repeat (5) @(posedge i_ref_clk);
		#1;
		chk({7'h0, o_sys_rst_n}, 8'h01);
		@(posedge i_ref_clk);
		i_clock_lost <= 1'b0;
		i_clock_loss_enable <= 1'b1;
		for (k = 0; k < 7; k++)
			src(k, sel_tab[k], cause_tab[k]);
		print_verdict();
	end
endmodule : watchdog_and_reset_sources_test
`default_nettype wire
